/* hdl/hft_pkg.sv */
package hft_pkg;

    // register selects {reg_select_high, reg_select_low}
    localparam logic [1:0] ADDR_CTRL1      = 2'h0;
    localparam logic [1:0] ADDR_CTRL2      = 2'h1;
    localparam logic [1:0] ADDR_TX_CONT    = 2'h2;
    localparam logic [1:0] ADDR_TX_TERM    = 2'h3;

    // first control register, read side is the status register
    localparam int         BIT_RX_RST      = 0;
    localparam int         BIT_TX_RST      = 1;
    localparam logic       RST_RX_RST      = 1'b1;
    localparam logic       RST_TX_RST      = 1'b1;

    // second control register
    localparam int         BIT_TWO_BYTE    = 0;
    localparam int         BIT_FLAG_IDLE   = 1;
    localparam int         BIT_TX_LAST     = 2;
    localparam logic       RST_TWO_BYTE    = 1'b0;
    localparam logic       RST_FLAG_IDLE   = 1'b0;

    // status register
    localparam int         BIT_ST_SPACE    = 0;
    localparam int         BIT_ST_EMPTY    = 1;
    localparam int         BIT_ST_IN_FRAME = 2;
    localparam int         BIT_ST_CTS_OFF  = 3;

    // transmit queue
    localparam int         FIFO_DEPTH      = 3;
    localparam logic [1:0] FIFO_FULL       = 2'h3;
    localparam logic [1:0] NEED_ONE        = 2'h1;
    localparam logic [1:0] NEED_TWO        = 2'h2;

    // line coding
    localparam logic [7:0]  FLAG_PATTERN   = 8'h7E;
    localparam logic [2:0]  STUFF_RUN      = 3'h5;
    localparam logic [3:0]  LAST_DATA_BIT  = 4'h7;
    localparam logic [3:0]  LAST_CRC_BIT   = 4'hF;
    localparam logic [15:0] CRC_INIT       = 16'hFFFF;
    localparam logic [15:0] CRC_POLY_REFL  = 16'h8408;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } hft_entry_t;

    typedef enum logic [1:0] {
        ST_MARK = 2'b00,
        ST_FLAG = 2'b01,
        ST_DATA = 2'b10,
        ST_CRC  = 2'b11
    } hft_state_t;

endpackage : hft_pkg

/* hdl/hft_transmitter.sv */
`timescale 1ns/1ps
// Behaviour
// - master reset holds the whole device in a latched reset state
// - clearing a section's soft reset bit releases only that section
// - soft reset release is ignored until master reset has gone high
// - setting a soft reset bit at any time resets that section again
// - transmit queue refuses data while the transmitter is in reset
// - after release send mark idle or flag fill as selected
// - idle fill lasts until the host loads data
// - transmit space status forced low in reset or with clear-to-send off
// - one-byte mode: status high when one queue byte is free
// - two-byte mode: status high only when two queue bytes are free
// - first byte written at frame-continue address starts a frame
// - from mark idle an opening flag begins within a few bit clocks
// - from flag fill the current flag opens the frame
// - frame continues while bytes arrive at the frame-continue address
// - byte written at frame-terminate address is the final data byte
// - transmit-last bit marks the most recent continue byte as final
// - after the final byte send check sequence then a closing flag
// - next frame's bytes queue behind the current frame without loss
// - a closing flag may double as the next opening flag
// - with no new frame, return to the selected idle fill
module hft_transmitter
    import hft_pkg::*;
(
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST_N,
    input  wire logic       I_REG_SELECT_HIGH,
    input  wire logic       I_REG_SELECT_LOW,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic [7:0]      O_RDATA,
    input  wire logic       I_TRANSMIT_BIT_CLOCK,
    input  wire logic       I_CTS_N,
    output logic            O_SERIAL_OUT,
    output logic            O_TX_SPACE_OR_FRAME_DONE,
    output logic            O_RECEIVER_SOFT_RESET
);

    logic [1:0] sel;
    logic       rst_ok_r;
    logic       rx_rst_r;
    logic       tx_rst_r;
    logic       two_byte_r;
    logic       flag_idle_r;
    logic       last_req;
    logic       push;
    logic       pop;
    logic       clk_s1_r;
    logic       clk_s2_r;
    logic       clk_s3_r;
    logic       cts_n_s1_r;
    logic       cts_n_s2_r;
    logic       tick;
    hft_entry_t wr_entry;
    hft_entry_t head;
    logic [1:0] fifo_cnt;
    logic [1:0] need;
    hft_state_t st_r;
    logic [15:0] sh_r;
    logic [3:0] bit_r;
    logic [2:0] ones_r;
    logic [15:0] crc_r;
    logic [15:0] crc_bit;
    logic       last_r;
    logic       close_r;
    logic       head_last;
    logic       serial_r;
    logic       space_r;
    logic [7:0] rdata_r;

    // reflected CCITT step, data sent least significant bit first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = (c >> 1) ^ (fb ? CRC_POLY_REFL : 16'h0000);
    endfunction : crc_step

    assign sel = {I_REG_SELECT_HIGH, I_REG_SELECT_LOW};

    // writes are only honoured one cycle after the master reset is gone
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_ok_r <= 1'b0;
        end else begin
            rst_ok_r <= 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rx_rst_r <= RST_RX_RST;
            tx_rst_r <= RST_TX_RST;
        end else if (I_WR && sel == ADDR_CTRL1 && rst_ok_r) begin
            rx_rst_r <= I_WDATA[BIT_RX_RST];
            tx_rst_r <= I_WDATA[BIT_TX_RST];
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            two_byte_r  <= RST_TWO_BYTE;
            flag_idle_r <= RST_FLAG_IDLE;
        end else if (I_WR && sel == ADDR_CTRL2 && rst_ok_r) begin
            two_byte_r  <= I_WDATA[BIT_TWO_BYTE];
            flag_idle_r <= I_WDATA[BIT_FLAG_IDLE];
        end
    end

    assign last_req = I_WR && sel == ADDR_CTRL2 && I_WDATA[BIT_TX_LAST] && !tx_rst_r;
    // a write into a full queue is dropped; software must watch the status
    assign push = I_WR && sel[1] && !tx_rst_r && fifo_cnt != FIFO_FULL;
    assign wr_entry.last = (sel == ADDR_TX_TERM);
    assign wr_entry.data = I_WDATA;

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            clk_s1_r   <= 1'b0;
            clk_s2_r   <= 1'b0;
            clk_s3_r   <= 1'b0;
            cts_n_s1_r <= 1'b1;
            cts_n_s2_r <= 1'b1;
        end else begin
            clk_s1_r   <= I_TRANSMIT_BIT_CLOCK;
            clk_s2_r   <= clk_s1_r;
            clk_s3_r   <= clk_s2_r;
            cts_n_s1_r <= I_CTS_N;
            cts_n_s2_r <= cts_n_s1_r;
        end
    end

    // bits change on the falling edge so the far end samples on the rising one
    assign tick = clk_s3_r && !clk_s2_r;

    hft_tx_fifo u_fifo (
        .i_clk       (I_REF_CLK),
        .i_rst_n     (I_RST_N),
        .i_flush     (tx_rst_r),
        .i_push      (push),
        .i_data      (wr_entry),
        .i_pop       (pop),
        .i_mark_last (last_req),
        .o_head      (head),
        .o_count     (fifo_cnt)
    );

    assign crc_bit = crc_step(crc_r, sh_r[0]);
    // a transmit-last that lands on the byte being popped must not be lost
    assign head_last = head.last || (last_req && fifo_cnt == 2'h1);
    assign pop = tick && !tx_rst_r && fifo_cnt != 2'h0 &&
                 ((st_r == ST_FLAG && bit_r == LAST_DATA_BIT) ||
                  (st_r == ST_DATA && ones_r != STUFF_RUN && bit_r == LAST_DATA_BIT
                   && !last_r));

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_r     <= ST_MARK;
            sh_r     <= 16'h0000;
            bit_r    <= 4'h0;
            ones_r   <= 3'h0;
            crc_r    <= CRC_INIT;
            last_r   <= 1'b0;
            close_r  <= 1'b0;
            serial_r <= 1'b1;
        end else if (tx_rst_r) begin
            st_r     <= ST_MARK;
            serial_r <= 1'b1;
            last_r   <= 1'b0;
            close_r  <= 1'b0;
        end else begin
            if (last_req && fifo_cnt == 2'h0 && st_r == ST_DATA) begin
                last_r <= 1'b1;
            end
            if (tick) begin
                case (st_r)
                    ST_MARK: begin
                        serial_r <= 1'b1;
                        if (fifo_cnt != 2'h0 || flag_idle_r) begin
                            st_r  <= ST_FLAG;
                            sh_r  <= {8'h00, FLAG_PATTERN};
                            bit_r <= 4'h0;
                        end
                    end
                    ST_FLAG: begin
                        serial_r <= sh_r[0];
                        sh_r     <= sh_r >> 1;
                        bit_r    <= bit_r + 4'h1;
                        if (bit_r == LAST_DATA_BIT) begin
                            bit_r <= 4'h0;
                            if (fifo_cnt != 2'h0) begin
                                st_r   <= ST_DATA;
                                sh_r   <= {8'h00, head.data};
                                last_r <= head_last;
                                crc_r  <= CRC_INIT;
                                ones_r <= 3'h0;
                            end else if (flag_idle_r) begin
                                sh_r <= {8'h00, FLAG_PATTERN};
                            end else begin
                                st_r <= ST_MARK;
                            end
                        end
                    end
                    ST_DATA, ST_CRC: begin
                        if (ones_r == STUFF_RUN) begin
                            serial_r <= 1'b0;
                            ones_r   <= 3'h0;
                            if (close_r) begin
                                close_r <= 1'b0;
                                st_r    <= ST_FLAG;
                                sh_r    <= {8'h00, FLAG_PATTERN};
                                bit_r   <= 4'h0;
                            end
                        end else begin
                            serial_r <= sh_r[0];
                            ones_r   <= sh_r[0] ? ones_r + 3'h1 : 3'h0;
                            sh_r     <= sh_r >> 1;
                            bit_r    <= bit_r + 4'h1;
                            if (st_r == ST_DATA) begin
                                crc_r <= crc_bit;
                                if (bit_r == LAST_DATA_BIT) begin
                                    bit_r <= 4'h0;
                                    // an empty queue mid-frame closes it cleanly
                                    if (last_r || fifo_cnt == 2'h0) begin
                                        st_r <= ST_CRC;
                                        sh_r <= ~crc_bit;
                                    end else begin
                                        sh_r   <= {8'h00, head.data};
                                        last_r <= head_last;
                                    end
                                end
                            end else if (bit_r == LAST_CRC_BIT) begin
                                // five ones at the very end still need their zero
                                if (sh_r[0] && ones_r == STUFF_RUN - 3'h1) begin
                                    close_r <= 1'b1;
                                end else begin
                                    st_r  <= ST_FLAG;
                                    sh_r  <= {8'h00, FLAG_PATTERN};
                                    bit_r <= 4'h0;
                                end
                            end
                        end
                    end
                    default: begin
                        st_r <= ST_MARK;
                    end
                endcase
            end
        end
    end

    assign need = two_byte_r ? NEED_TWO : NEED_ONE;

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            space_r <= 1'b0;
        end else begin
            space_r <= !tx_rst_r && !cts_n_s2_r &&
                       (FIFO_FULL - fifo_cnt) >= need;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_r <= 8'h00;
        end else if (I_RD) begin
            case (sel)
                ADDR_CTRL1: begin
                    rdata_r <= 8'h00;
                    rdata_r[BIT_ST_SPACE]    <= space_r;
                    rdata_r[BIT_ST_EMPTY]    <= fifo_cnt == 2'h0;
                    rdata_r[BIT_ST_IN_FRAME] <= st_r == ST_DATA || st_r == ST_CRC;
                    rdata_r[BIT_ST_CTS_OFF]  <= cts_n_s2_r;
                end
                ADDR_CTRL2: begin
                    rdata_r <= 8'h00;
                    rdata_r[BIT_TWO_BYTE]  <= two_byte_r;
                    rdata_r[BIT_FLAG_IDLE] <= flag_idle_r;
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign O_RDATA                  = rdata_r;
    assign O_SERIAL_OUT             = serial_r;
    assign O_TX_SPACE_OR_FRAME_DONE = space_r;
    assign O_RECEIVER_SOFT_RESET    = rx_rst_r;

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_N);

    sequence s_last_bit_out;
        st_r == ST_DATA && tick && ones_r != STUFF_RUN && bit_r == LAST_DATA_BIT && last_r;
    endsequence

    sequence s_crc_loaded;
        st_r == ST_CRC && bit_r == 4'h0;
    endsequence

    reset_held_a: assert property ($rose(rst_ok_r) |-> tx_rst_r && rx_rst_r)
        else $error("sections not held in reset after master reset");
    early_release_a: assert property (!rst_ok_r |=> $stable(tx_rst_r))
        else $error("transmitter reset changed before master reset release");
    soft_reset_a: assert property (I_WR && sel == ADDR_CTRL1 && I_WDATA[BIT_TX_RST]
                                   |=> tx_rst_r ##1 st_r == ST_MARK)
        else $error("transmitter reset bit did not reset the section");
    no_preload_a: assert property (tx_rst_r && $past(tx_rst_r) |-> fifo_cnt == 2'h0)
        else $error("queue held data during transmitter reset");
    status_gate_a: assert property (tx_rst_r || cts_n_s2_r |=> !O_TX_SPACE_OR_FRAME_DONE)
        else $error("space status high while inhibited");
    two_byte_a: assert property (O_TX_SPACE_OR_FRAME_DONE && $past(two_byte_r)
                                 |-> $past(fifo_cnt) <= 2'h1)
        else $error("space status high with fewer than two free bytes");
    mark_idle_a: assert property (st_r == ST_MARK && tick && !tx_rst_r |=> O_SERIAL_OUT)
        else $error("mark idle did not send a one");
    open_flag_a: assert property (st_r == ST_MARK && tick && !tx_rst_r && fifo_cnt != 2'h0
                                  |=> st_r == ST_FLAG && bit_r == 4'h0)
        else $error("loaded byte did not start an opening flag");
    zero_stuff_a: assert property (st_r == ST_DATA && tick && ones_r == STUFF_RUN && !tx_rst_r
                                   |=> !O_SERIAL_OUT)
        else $error("no zero inserted after five ones");
    crc_follows_a: assert property (s_last_bit_out and !tx_rst_r |=> s_crc_loaded)
        else $error("check sequence did not follow the final byte");
    end_stuff_a: assert property (close_r && tick && !tx_rst_r
                                  |=> !O_SERIAL_OUT && st_r == ST_FLAG)
        else $error("no zero inserted before the closing flag");
    flag_fill_a: assert property (st_r == ST_MARK && tick && !tx_rst_r && flag_idle_r
                                  |=> st_r == ST_FLAG)
        else $error("flag idle did not start flags");
    one_byte_a: assert property (!two_byte_r && !tx_rst_r && !cts_n_s2_r && fifo_cnt != FIFO_FULL
                                 |=> O_TX_SPACE_OR_FRAME_DONE)
        else $error("space status low with a free byte");
    idle_return_a: assert property (st_r == ST_FLAG && tick && bit_r == LAST_DATA_BIT
                                    && fifo_cnt == 2'h0 && !flag_idle_r && !tx_rst_r
                                    |=> st_r == ST_MARK)
        else $error("mark idle not resumed after closing flag");

endmodule : hft_transmitter

/* hdl/hft_tx_fifo.sv */
`timescale 1ns/1ps
module hft_tx_fifo
    import hft_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_flush,
    input  wire logic       i_push,
    input  hft_entry_t      i_data,
    input  wire logic       i_pop,
    input  wire logic       i_mark_last,
    output hft_entry_t      o_head,
    output logic [1:0]      o_count
);

    hft_entry_t mem_r   [FIFO_DEPTH];
    hft_entry_t mem_nxt [FIFO_DEPTH];
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;

    always_comb begin
        mem_nxt = mem_r;
        cnt_nxt = cnt_r;
        // mark before the shift so the index still points at the newest entry
        if (i_mark_last && cnt_r != 2'h0) begin
            mem_nxt[cnt_r - 2'h1].last = 1'b1;
        end
        if (i_pop && cnt_r != 2'h0) begin
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                mem_nxt[i] = mem_nxt[i + 1];
            end
            cnt_nxt = cnt_nxt - 2'h1;
        end
        if (i_push && cnt_nxt != FIFO_FULL) begin
            mem_nxt[cnt_nxt] = i_data;
            cnt_nxt          = cnt_nxt + 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 2'h0;
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (i_flush) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end

    assign o_head  = mem_r[0];
    assign o_count = cnt_r;

endmodule : hft_tx_fifo

/* verification/hft_remote_station.sv */
`timescale 1ns/1ps
module hft_remote_station (
    input  wire logic i_run,
    input  wire logic i_serial,
    output logic      o_bit_clock
);
    logic bits[$];

    // clock parks high when stopped so the sender sees no stray falling edge
    initial begin
        o_bit_clock = 1'b1;
        forever begin
            if (i_run) begin
                #32 o_bit_clock = 1'b0;
                #32 o_bit_clock = 1'b1;
            end else begin
                #8;
            end
        end
    end

    // sender changes the line after the falling edge, so rising edge sees settled bits
    always @(posedge o_bit_clock) begin
        bits.push_back(i_serial);
    end
endmodule : hft_remote_station

/* verification/tb_hdlc_frame_transmitter.sv */
`timescale 1ns/1ps
module tb_hdlc_frame_transmitter;
    import hft_pkg::*;
    logic        clk, rst_n, sel_h, sel_l, wr_s, rd_s, cts_n, run;
    logic [7:0]  wdata, rdata, st, mode;
    logic        bit_clk, ser, space, rx_rst;
    logic [31:0] seed;
    logic        ex[$];
    logic [7:0]  q1[$], q2[$];
    int          fail_count, total_checks, pos;

    hft_transmitter dut_u (
        .I_REF_CLK               (clk),
        .I_RST_N                 (rst_n),
        .I_REG_SELECT_HIGH       (sel_h),
        .I_REG_SELECT_LOW        (sel_l),
        .I_WDATA                 (wdata),
        .I_WR                    (wr_s),
        .I_RD                    (rd_s),
        .O_RDATA                 (rdata),
        .I_TRANSMIT_BIT_CLOCK    (bit_clk),
        .I_CTS_N                 (cts_n),
        .O_SERIAL_OUT            (ser),
        .O_TX_SPACE_OR_FRAME_DONE(space),
        .O_RECEIVER_SOFT_RESET   (rx_rst)
    );
    hft_remote_station rem_u (.i_run(run), .i_serial(ser), .o_bit_clock(bit_clk));

    always #2.5 clk = ~clk;

    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    function logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        {sel_h, sel_l} <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task rd(input logic [1:0] a);
        @(posedge clk);
        {sel_h, sel_l} <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 st = rdata;
    endtask : rd

    task put(input logic [1:0] a, input logic [7:0] d);
        int n;
        for (n = 0; n < 4000; n++) begin
            @(posedge clk);
            #1;
            if (space === 1'b1) break;
        end
        chk({7'h0, n < 4000}, 8'h01, "no space");
        if (n == 4000) complete_run();
        wr(a, d);
        @(posedge clk);
    endtask : put

    task automatic send_frame(input logic [7:0] q[$], input logic term);
        foreach (q[k]) put((term && k == q.size() - 1) ? ADDR_TX_TERM : ADDR_TX_CONT, q[k]);
        if (!term) wr(ADDR_CTRL2, mode | 8'h04);
    endtask : send_frame

    task automatic add_bit(input logic b, inout int ones, input logic stuff);
        ex.push_back(b);
        ones = b ? ones + 1 : 0;
        if (stuff && ones == 5) begin
            ex.push_back(1'b0);
            ones = 0;
        end
    endtask : add_bit

    // expected line image: flag, stuffed bytes and check sequence, flag
    task automatic build(input logic [7:0] q[$]);
        logic [15:0] c;
        int          ones;
        c = CRC_INIT;
        ones = 0;
        ex.delete();
        for (int i = 0; i < 8; i++) add_bit(FLAG_PATTERN[i], ones, 1'b0);
        foreach (q[k]) begin
            for (int i = 0; i < 8; i++) begin
                add_bit(q[k][i], ones, 1'b1);
                c = (c[0] ^ q[k][i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
            end
        end
        c = ~c;
        for (int i = 0; i < 16; i++) add_bit(c[i], ones, 1'b1);
        for (int i = 0; i < 8; i++) add_bit(FLAG_PATTERN[i], ones, 1'b0);
    endtask : build

    function automatic int find();
        logic ok;
        for (int i = 0; i + ex.size() <= rem_u.bits.size(); i++) begin
            ok = 1'b1;
            foreach (ex[k]) ok &= (rem_u.bits[i + k] === ex[k]);
            if (ok) return i;
        end
        return -1;
    endfunction : find

    function automatic logic all_ones(input int n);
        logic r;
        r = 1'b1;
        for (int i = rem_u.bits.size() - n; i < rem_u.bits.size(); i++) begin
            r &= (rem_u.bits[i] === 1'b1);
        end
        return r;
    endfunction : all_ones

    task wait_bits(input int n);
        int i;
        for (i = 0; i < 8000 && rem_u.bits.size() < n; i++) @(posedge clk);
        chk({7'h0, i < 8000}, 8'h01, "bit clock stalled");
        if (i == 8000) complete_run();
    endtask : wait_bits

    task automatic expect_frame(input logic [7:0] q[$], input int lim);
        build(q);
        pos = -1;
        for (int n = 0; n < 800 && pos < 0; n++) begin
            repeat (13) @(posedge clk);
            pos = find();
        end
        chk({7'h0, pos >= 0 && pos <= lim}, 8'h01, "frame on line");
        if (pos < 0) complete_run();
        wait_bits(pos + ex.size() + 16);
        if (lim < 8) chk({7'h0, all_ones(16)}, 8'h01, "mark after frame");
    endtask : expect_frame

    initial begin
        {clk, rst_n, sel_h, sel_l, wr_s, rd_s, cts_n, run} = '0;
        {wdata, mode, fail_count, total_checks} = '0;
        seed = 32'ha3b6;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({5'h0, ser, space, rx_rst}, 8'h05, "reset outputs");
        wr(ADDR_CTRL2, mode);
        wr(ADDR_TX_CONT, 8'h55);
        rd(ADDR_CTRL1);
        chk(st & 8'h07, 8'h02, "queue loaded in reset");
        rd(ADDR_TX_TERM);
        chk(st, 8'h00, "data address read");
        $display("test reset done");
        run <= 1'b1;
        wr(ADDR_CTRL1, 8'h01);
        repeat (4) @(posedge clk);
        chk({6'h0, rx_rst, space}, 8'h03, "tx only released");
        cts_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(ADDR_CTRL1);
        chk({space, st[3:0]}, 8'h0A, "clear to send off");
        cts_n <= 1'b0;
        rem_u.bits.delete();
        wait_bits(16);
        chk({7'h0, all_ones(16)}, 8'h01, "mark idle");
        $display("test release done");
        q1 = '{rnd(), 8'hFF, rnd()};
        rem_u.bits.delete();
        send_frame(q1, 1'b1);
        expect_frame(q1, 3);
        q1 = '{rnd(), rnd()};
        rem_u.bits.delete();
        send_frame(q1, 1'b0);
        expect_frame(q1, 3);
        $display("test frame end methods done");
        run <= 1'b0;
        q1 = '{rnd(), rnd(), rnd()};
        mode = 8'h01;
        wr(ADDR_CTRL2, mode);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_TX_CONT, q1[k]);
            repeat (3) @(posedge clk);
            chk({7'h0, space}, {7'h0, k == 0}, "two byte space");
            if (k == 1) mode = 8'h00;
            if (k == 1) wr(ADDR_CTRL2, mode);
            if (k == 1) repeat (3) @(posedge clk);
            if (k == 1) chk({7'h0, space}, 8'h01, "one byte space");
        end
        wr(ADDR_TX_TERM, 8'hAA);
        wr(ADDR_CTRL2, 8'h04);
        rem_u.bits.delete();
        run <= 1'b1;
        expect_frame(q1, 3);
        $display("test transfer modes done");
        mode = 8'h02;
        wr(ADDR_CTRL2, mode);
        rem_u.bits.delete();
        wait_bits(40);
        ex = '{0, 1, 1, 1, 1, 1, 1, 0, 0, 1, 1, 1, 1, 1, 1, 0};
        chk({7'h0, find() >= 0}, 8'h01, "flag fill");
        q1 = '{rnd(), rnd()};
        q2 = '{8'h7E, rnd(), 8'hF8};
        send_frame(q1, 1'b1);
        send_frame(q2, 1'b1);
        expect_frame(q1, 100000);
        expect_frame(q2, 100000);
        $display("test flag fill done");
        wr(ADDR_CTRL1, 8'h00);
        repeat (3) @(posedge clk);
        chk({7'h0, rx_rst}, 8'h00, "rx released");
        q1 = '{rnd(), rnd()};
        send_frame(q1, 1'b0);
        wr(ADDR_CTRL1, 8'h03);
        repeat (4) @(posedge clk);
        chk({6'h0, rx_rst, space}, 8'h02, "soft reset again");
        rem_u.bits.delete();
        wait_bits(24);
        chk({7'h0, all_ones(24)}, 8'h01, "line held at mark");
        rst_n <= 1'b0;
        wr(ADDR_CTRL1, 8'h00);
        repeat (2) @(posedge clk);
        chk({5'h0, ser, space, rx_rst}, 8'h05, "master reset");
        rst_n <= 1'b1;
        {sel_h, sel_l} <= ADDR_CTRL1;
        wdata <= 8'h00;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        repeat (8) @(posedge clk);
        chk({5'h0, ser, space, rx_rst}, 8'h05, "release needs software");
        $display("test resets done");
        run <= 1'b0;
        complete_run();
    end
endmodule : tb_hdlc_frame_transmitter
